// File: common/prc_defines.vh
// Purpose: Constants for the pin remap and port control block
// Assumes: APB byte addresses, 12-bit address decode
// Notes: Pin index is port * 8 + line, ports A..G = 0..6
`ifndef PRC_DEFINES_VH
`define PRC_DEFINES_VH

// ==========================================================
// Register offsets
`define PRC_OFF_IN_REMAP 12'h000
`define PRC_OFF_OUT_REMAP 12'h004
`define PRC_OFF_WAKE_EN 12'h008
`define PRC_OFF_BIT_OP 12'h00C
`define PRC_OFF_DATA0 12'h010
`define PRC_OFF_DIR0 12'h030
`define PRC_OFF_PIN0 12'h050
`define PRC_NUM_PORTS 7

// ==========================================================
// Reset values
`define PRC_RST_REMAP 8'h00
`define PRC_RST_PORT 8'hFF
`define PRC_RST_WAKE_EN 8'h00
`define PRC_NARROW_WMASK 8'h3F

// ==========================================================
// Bit operation word fields
`define PRC_BOP_BIT_LSB 0
`define PRC_BOP_PORT_LSB 4
`define PRC_BOP_DIR_BIT 8
`define PRC_BOP_VAL_BIT 9

// ==========================================================
// Pin indices
`define PRC_PIN_A0 6'd0
`define PRC_PIN_A1 6'd1
`define PRC_PIN_A2 6'd2
`define PRC_PIN_A3 6'd3
`define PRC_PIN_A4 6'd4
`define PRC_PIN_A5 6'd5
`define PRC_PIN_C2 6'd18
`define PRC_PIN_C3 6'd19
`define PRC_PIN_C4 6'd20
`define PRC_PIN_C5 6'd21
`define PRC_PIN_C6 6'd22
`define PRC_PIN_C7 6'd23
`define PRC_PIN_D0 6'd24
`define PRC_PIN_D1 6'd25
`define PRC_PIN_D2 6'd26
`define PRC_PIN_D3 6'd27
`define PRC_PIN_D4 6'd28
`define PRC_PIN_D5 6'd29
`define PRC_PIN_E0 6'd32
`define PRC_PIN_E1 6'd33
`define PRC_PIN_E2 6'd34
`define PRC_PIN_E3 6'd35
`define PRC_PIN_E4 6'd36
`define PRC_PIN_E5 6'd37
`define PRC_PIN_E6 6'd38
`define PRC_PIN_E7 6'd39

`endif

// File: logic/prc_pin_remap.v
// Purpose: Pin remapping, port latches and port A wake-up
// Assumes: APB slave, zero wait states, pad inputs synchronous
// Notes: Mux paths from pads to timers are combinational
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"

module prc_pin_remap #(
   parameter NARROW_VARIANT = 0
) (
   // Clock and reset
   input wire clk_sys,
   input wire rst_n,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output wire [31:0] prdata,
   // Port A
   input wire [7:0] pa_in,
   output wire [7:0] pa_out,
   output wire [7:0] pa_oe,
   // Port B
   input wire [7:0] pb_in,
   output wire [7:0] pb_out,
   output wire [7:0] pb_oe,
   // Port C
   input wire [7:0] pc_in,
   output wire [7:0] pc_out,
   output wire [7:0] pc_oe,
   // Port D
   input wire [7:0] pd_in,
   output wire [7:0] pd_out,
   output wire [7:0] pd_oe,
   // Port E
   input wire [7:0] pe_in,
   output wire [7:0] pe_out,
   output wire [7:0] pe_oe,
   // Port F
   input wire [7:0] pf_in,
   output wire [7:0] pf_out,
   output wire [7:0] pf_oe,
   // Port G
   input wire [7:0] pg_in,
   output wire [7:0] pg_out,
   output wire [7:0] pg_oe,
   // Timer outputs and their pin enables
   input wire timer3_out1,
   input wire timer3_out0,
   input wire timer2_out1,
   input wire timer2_out0,
   input wire timer1_chb_out2,
   input wire timer1_cha_out,
   input wire timer0_out1,
   input wire timer0_out0,
   input wire [7:0] timer_out_en,
   // Routed inputs to timers and interrupts
   output wire timer2_clock_in,
   output wire timer1_clock_in,
   output wire timer0_clock_in,
   output wire ext_irq2_in,
   output wire ext_irq1_in,
   output wire ext_irq0_in,
   // Power mode and wake-up
   input wire sleep_mode,
   output wire wake_req
);

   // ==========================================================
   // Declarations
   reg [7:0] input_pin_remap_q;
   reg [7:0] timer_output_remap_q;
   reg [7:0] wake_en_q;
   reg [7:0] pa_prev_q;
   reg wake_q;
   reg [31:0] prdata_q;
   reg [7:0] rd_byte;
   reg mapped;
   reg [55:0] func_en;
   reg [55:0] func_val;
   wire [55:0] pin_in;
   wire [55:0] latch_flat;
   wire [55:0] dir_flat;
   wire [55:0] pad_out_flat;
   wire [55:0] pad_oe_flat;
   wire apb_setup;
   wire apb_access;
   wire apb_wr;
   wire bop_wr;
   wire [2:0] bop_bit;
   wire [2:0] bop_port;
   wire bop_dir;
   wire bop_val;
   wire [7:0] bop_mask;
   wire [7:0] out_wmask;
   wire t3_ok;
   integer i;

   assign pin_in = {pg_in, pf_in, pe_in, pd_in, pc_in, pb_in, pa_in};

   // ==========================================================
   // APB handshake
   assign apb_setup = psel & ~penable;
   assign apb_access = psel & penable;
   assign apb_wr = apb_access & pwrite & mapped;
   assign pready = 1'b1;
   assign pslverr = apb_access & ~mapped;
   assign prdata = prdata_q;

   // Read decode, also defines which addresses answer
   always @*
   begin
      rd_byte = 8'h00;
      mapped = 1'b0;
      case (paddr)
         `PRC_OFF_IN_REMAP: rd_byte = input_pin_remap_q;
         `PRC_OFF_OUT_REMAP: rd_byte = timer_output_remap_q;
         `PRC_OFF_WAKE_EN: rd_byte = wake_en_q;
         default: rd_byte = 8'h00;
      endcase
      mapped = (paddr == `PRC_OFF_IN_REMAP) | (paddr == `PRC_OFF_OUT_REMAP) |
         (paddr == `PRC_OFF_WAKE_EN) | (paddr == `PRC_OFF_BIT_OP);
      for (i = 0; i < `PRC_NUM_PORTS; i = i + 1)
      begin
         if (paddr == `PRC_OFF_DATA0 + 4 * i)
         begin
            mapped = 1'b1;
            rd_byte = latch_flat[i*8 +: 8];
         end
         if (paddr == `PRC_OFF_DIR0 + 4 * i)
         begin
            mapped = 1'b1;
            rd_byte = dir_flat[i*8 +: 8];
         end
         if (paddr == `PRC_OFF_PIN0 + 4 * i)
         begin
            mapped = 1'b1;
            rd_byte = pin_in[i*8 +: 8];
         end
      end
   end

   // Read data captured in setup so prdata comes from a flop
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         prdata_q <= 32'h0000_0000;
      end
      else if (apb_setup && !pwrite)
      begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   // ==========================================================
   // Remap and wake enable registers
   assign t3_ok = (NARROW_VARIANT == 0);
   assign out_wmask = t3_ok ? 8'hFF : `PRC_NARROW_WMASK;

   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         input_pin_remap_q <= `PRC_RST_REMAP;
         timer_output_remap_q <= `PRC_RST_REMAP;
         wake_en_q <= `PRC_RST_WAKE_EN;
      end
      else if (apb_wr)
      begin
         if (paddr == `PRC_OFF_IN_REMAP)
            input_pin_remap_q <= pwdata[7:0];
         if (paddr == `PRC_OFF_OUT_REMAP)
            timer_output_remap_q <= pwdata[7:0] & out_wmask;
         if (paddr == `PRC_OFF_WAKE_EN)
            wake_en_q <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Single bit set or clear
   assign bop_wr = apb_wr & (paddr == `PRC_OFF_BIT_OP);
   assign bop_bit = pwdata[`PRC_BOP_BIT_LSB +: 3];
   assign bop_port = pwdata[`PRC_BOP_PORT_LSB +: 3];
   assign bop_dir = pwdata[`PRC_BOP_DIR_BIT];
   assign bop_val = pwdata[`PRC_BOP_VAL_BIT];
   assign bop_mask = 8'h01 << bop_bit;

   // ==========================================================
   // Port data and direction latches
   genvar p;
   generate
      for (p = 0; p < `PRC_NUM_PORTS; p = p + 1)
      begin : g_port
         reg [7:0] data_q;
         reg [7:0] dir_q;
         wire bop_hit;
         wire [7:0] port_rd;
         assign bop_hit = bop_wr & (bop_port == p);
         // Pins, not latch: input lines may overwrite latch bits
         assign port_rd = pin_in[p*8 +: 8];
         always @(posedge clk_sys)
         begin
            if (!rst_n)
            begin
               data_q <= `PRC_RST_PORT;
               dir_q <= `PRC_RST_PORT;
            end
            else
            begin
               if (apb_wr && paddr == `PRC_OFF_DATA0 + 4 * p)
               begin
                  data_q <= pwdata[7:0];
               end
               else if (bop_hit && !bop_dir)
               begin
                  data_q <= (port_rd & ~bop_mask) | (bop_val ? bop_mask : 8'h00);
               end
               if (apb_wr && paddr == `PRC_OFF_DIR0 + 4 * p)
               begin
                  dir_q <= pwdata[7:0];
               end
               else if (bop_hit && bop_dir)
               begin
                  dir_q <= (dir_q & ~bop_mask) | (bop_val ? bop_mask : 8'h00);
               end
            end
         end
         assign latch_flat[p*8 +: 8] = data_q;
         assign dir_flat[p*8 +: 8] = dir_q;
      end
   endgenerate

   // ==========================================================
   // Input routing
   // timer2 clock select
   assign timer2_clock_in = input_pin_remap_q[7] ? pin_in[`PRC_PIN_D0] : pin_in[`PRC_PIN_C2];
   assign timer1_clock_in = input_pin_remap_q[6] ? pin_in[`PRC_PIN_D3] : pin_in[`PRC_PIN_A4];
   assign timer0_clock_in = input_pin_remap_q[5] ? pin_in[`PRC_PIN_D2] : pin_in[`PRC_PIN_A2];
   assign ext_irq2_in = input_pin_remap_q[4] ? pin_in[`PRC_PIN_E2] : pin_in[`PRC_PIN_A5];

   reg irq1_mux;
   reg irq0_mux;
   always @*
   begin
      case (input_pin_remap_q[3:2])
         2'b00: irq1_mux = pin_in[`PRC_PIN_A4];
         2'b01: irq1_mux = pin_in[`PRC_PIN_C5];
         2'b10: irq1_mux = pin_in[`PRC_PIN_E1];
         default: irq1_mux = pin_in[`PRC_PIN_E7];
      endcase
      case (input_pin_remap_q[1:0])
         2'b00: irq0_mux = pin_in[`PRC_PIN_A3];
         2'b01: irq0_mux = pin_in[`PRC_PIN_C4];
         2'b10: irq0_mux = pin_in[`PRC_PIN_E0];
         default: irq0_mux = pin_in[`PRC_PIN_E6];
      endcase
   end
   assign ext_irq1_in = irq1_mux;
   assign ext_irq0_in = irq0_mux;

   // ==========================================================
   // Output routing
   function [55:0] pin_bit;
      input [5:0] idx;
      begin
         pin_bit = 56'h00_0000_0000_0001 << idx;
      end
   endfunction

   function [55:0] route;
      input en;
      input sel;
      input [5:0] pin_dflt;
      input [5:0] pin_alt;
      begin
         route = en ? pin_bit(sel ? pin_alt : pin_dflt) : 56'h00_0000_0000_0000;
      end
   endfunction

   // Shared pins simply OR; software must avoid such clashes
   always @*
   begin
      func_en = 56'h00_0000_0000_0000;
      func_val = 56'h00_0000_0000_0000;
      func_en = func_en | route(timer_out_en[7] & t3_ok, timer_output_remap_q[7],
         `PRC_PIN_D0, `PRC_PIN_E3);
      func_val = func_val | route(timer_out_en[7] & t3_ok & timer3_out1,
         timer_output_remap_q[7], `PRC_PIN_D0, `PRC_PIN_E3);
      func_en = func_en | route(timer_out_en[6] & t3_ok, timer_output_remap_q[6],
         `PRC_PIN_D3, `PRC_PIN_E5);
      func_val = func_val | route(timer_out_en[6] & t3_ok & timer3_out0,
         timer_output_remap_q[6], `PRC_PIN_D3, `PRC_PIN_E5);
      func_en = func_en | route(timer_out_en[5], timer_output_remap_q[5],
         `PRC_PIN_C4, `PRC_PIN_D4);
      func_val = func_val | route(timer_out_en[5] & timer2_out1,
         timer_output_remap_q[5], `PRC_PIN_C4, `PRC_PIN_D4);
      func_en = func_en | route(timer_out_en[4], timer_output_remap_q[4],
         `PRC_PIN_C3, `PRC_PIN_D1);
      func_val = func_val | route(timer_out_en[4] & timer2_out0,
         timer_output_remap_q[4], `PRC_PIN_C3, `PRC_PIN_D1);
      func_en = func_en | route(timer_out_en[3], timer_output_remap_q[3],
         `PRC_PIN_C5, `PRC_PIN_E4);
      func_val = func_val | route(timer_out_en[3] & timer1_chb_out2,
         timer_output_remap_q[3], `PRC_PIN_C5, `PRC_PIN_E4);
      func_en = func_en | route(timer_out_en[2], timer_output_remap_q[2],
         `PRC_PIN_A1, `PRC_PIN_C7);
      func_val = func_val | route(timer_out_en[2] & timer1_cha_out,
         timer_output_remap_q[2], `PRC_PIN_A1, `PRC_PIN_C7);
      func_en = func_en | route(timer_out_en[1], timer_output_remap_q[1],
         `PRC_PIN_C5, `PRC_PIN_D5);
      func_val = func_val | route(timer_out_en[1] & timer0_out1,
         timer_output_remap_q[1], `PRC_PIN_C5, `PRC_PIN_D5);
      func_en = func_en | route(timer_out_en[0], timer_output_remap_q[0],
         `PRC_PIN_A0, `PRC_PIN_C6);
      func_val = func_val | route(timer_out_en[0] & timer0_out0,
         timer_output_remap_q[0], `PRC_PIN_A0, `PRC_PIN_C6);
   end

   // ==========================================================
   // Pad drivers
   // latch value drives output, except on pins where an enabled timer function drives its value
   assign pad_out_flat = (func_en & func_val) | (~func_en & latch_flat);
   assign pad_oe_flat = ~dir_flat | func_en;

   assign {pg_out, pf_out, pe_out, pd_out, pc_out, pb_out, pa_out} = pad_out_flat;
   assign {pg_oe, pf_oe, pe_oe, pd_oe, pc_oe, pb_oe, pa_oe} = pad_oe_flat;

   // ==========================================================
   // Port A wake-up
   // Previous levels reset high, so a pin low at reset release reads as a falling edge
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         pa_prev_q <= 8'hFF;
         wake_q <= 1'b0;
      end
      else
      begin
         pa_prev_q <= pa_in;
         wake_q <= sleep_mode & (|(wake_en_q & pa_prev_q & ~pa_in));
      end
   end
   assign wake_req = wake_q;

endmodule // prc_pin_remap
`default_nettype wire

// File: test/prc_pin_remap_checker.sv
// Purpose: Port checks for the pin remap block
// Assumes: Full variant, APB writes land at the access edge
// Notes: Shadows of the remap and wake words follow APB writes
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"
module prc_pin_remap_checker (
   // Clock, reset, APB
   input wire clk_sys,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   // Pads and pins
   input wire [7:0] pa_in,
   input wire [7:0] pc_in,
   input wire [7:0] pd_in,
   input wire [7:0] pe_in,
   input wire [7:0] pb_out,
   input wire [7:0] pb_oe,
   input wire [7:0] pd_out,
   input wire [7:0] pd_oe,
   input wire [7:0] pe_out,
   input wire [7:0] pe_oe,
   // Timers, routed inputs, wake
   input wire timer3_out1,
   input wire timer3_out0,
   input wire [7:0] timer_out_en,
   input wire timer2_clock_in,
   input wire timer1_clock_in,
   input wire timer0_clock_in,
   input wire ext_irq2_in,
   input wire ext_irq1_in,
   input wire ext_irq0_in,
   input wire sleep_mode,
   input wire wake_req
);
   reg [7:0] in_q;
   reg [7:0] out_q;
   reg [7:0] wen_q;
   wire wr_en = psel && penable && pwrite;
   // ==========================================
   // Shadow registers
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         in_q <= 8'h00;
         out_q <= 8'h00;
         wen_q <= 8'h00;
      end
      else if (wr_en)
      begin
         if (paddr == `PRC_OFF_IN_REMAP)
            in_q <= pwdata[7:0];
         if (paddr == `PRC_OFF_OUT_REMAP)
            out_q <= pwdata[7:0];
         if (paddr == `PRC_OFF_WAKE_EN)
            wen_q <= pwdata[7:0];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Properties
   // First edge after reset has no valid previous pad sample
   sequence s_fall;
      sleep_mode && $past(rst_n) && |(wen_q & $past(pa_in) & ~pa_in);
   endsequence
   property p_t2clk;
      timer2_clock_in == (in_q[7] ? pd_in[0] : pc_in[2]);
   endproperty
   property p_t1clk;
      timer1_clock_in == (in_q[6] ? pd_in[3] : pa_in[4]);
   endproperty
   property p_t0clk;
      timer0_clock_in == (in_q[5] ? pd_in[2] : pa_in[2]);
   endproperty
   property p_irq2;
      ext_irq2_in == (in_q[4] ? pe_in[2] : pa_in[5]);
   endproperty
   property p_irq1;
      ext_irq1_in == (in_q[3] ? (in_q[2] ? pe_in[7] : pe_in[1]) : (in_q[2] ? pc_in[5] : pa_in[4]));
   endproperty
   property p_irq0;
      ext_irq0_in == (in_q[1] ? (in_q[0] ? pe_in[6] : pe_in[0]) : (in_q[0] ? pc_in[4] : pa_in[3]));
   endproperty
   property p_rst;
      disable iff (1'b0) !rst_n |=> (pb_oe == 8'h00 && pb_out == 8'hFF);
   endproperty
   property p_t3o1;
      timer_out_en[7] && !out_q[7] |-> pd_oe[0] && pd_out[0] == timer3_out1;
   endproperty
   property p_t3o0;
      timer_out_en[6] && out_q[6] |-> pe_oe[5] && pe_out[5] == timer3_out0;
   endproperty
   property p_wake;
      s_fall |=> wake_req;
   endproperty
   property p_wsrc;
      wake_req |-> $past(sleep_mode);
   endproperty
   property p_rdz;
      prdata[31:8] == 24'h00_0000;
   endproperty
   a_t2clk: assert property (p_t2clk) else $error("timer2 clock route wrong");
   a_t1clk: assert property (p_t1clk) else $error("timer1 clock route wrong");
   a_t0clk: assert property (p_t0clk) else $error("timer0 clock route wrong");
   a_irq2: assert property (p_irq2) else $error("irq2 route wrong");
   a_irq1: assert property (p_irq1) else $error("irq1 route wrong");
   a_irq0: assert property (p_irq0) else $error("irq0 route wrong");
   a_rst: assert property (p_rst) else $error("port not input high after reset");
   a_t3o1: assert property (p_t3o1) else $error("timer3 out1 pin wrong");
   a_t3o0: assert property (p_t3o0) else $error("timer3 out0 pin wrong");
   a_wake: assert property (p_wake) else $error("missing wake pulse");
   a_wsrc: assert property (p_wsrc) else $error("wake outside sleep");
   a_rdz: assert property (p_rdz) else $error("upper read data not zero");
endmodule // prc_pin_remap_checker
bind prc_pin_remap prc_pin_remap_checker prc_pin_remap_checker_i (.*);
`default_nettype wire

// File: test/prc_pin_remap_test.sv
// Purpose: Self-checking bench for the pin remap block
// Assumes: Zero-wait APB slave, full output remap variant
// Notes: Bench drives pads directly, pins index as port * 8 + line
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.vh"
module prc_pin_remap_test;
   localparam int PIN_T [16] = '{0, 22, 21, 29, 1, 23, 21, 36, 19, 25, 20, 28, 27, 37, 24, 35};
   logic clk_sys, rst_n, psel, penable, pwrite, sleep_mode, err_v, w;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd_v, r, e;
   logic [7:0] timer_out_en, tv;
   logic [55:0] pv;
   wire pready, pslverr, wake_req;
   wire [31:0] prdata;
   wire [7:0] pa_in, pb_in, pc_in, pd_in, pe_in, pf_in, pg_in;
   wire [7:0] pa_out, pb_out, pc_out, pd_out, pe_out, pf_out, pg_out;
   wire [7:0] pa_oe, pb_oe, pc_oe, pd_oe, pe_oe, pf_oe, pg_oe;
   wire timer3_out1, timer3_out0, timer2_out1, timer2_out0;
   wire timer1_chb_out2, timer1_cha_out, timer0_out1, timer0_out0;
   wire timer2_clock_in, timer1_clock_in, timer0_clock_in;
   wire ext_irq2_in, ext_irq1_in, ext_irq0_in;
   wire [55:0] oe_v = {pg_oe, pf_oe, pe_oe, pd_oe, pc_oe, pb_oe, pa_oe};
   wire [55:0] out_v = {pg_out, pf_out, pe_out, pd_out, pc_out, pb_out, pa_out};
   int n_fail, n_tests, k, b, seed;
   assign {pg_in, pf_in, pe_in, pd_in, pc_in, pb_in, pa_in} = pv;
   assign {timer3_out1, timer3_out0, timer2_out1, timer2_out0} = tv[7:4];
   assign {timer1_chb_out2, timer1_cha_out, timer0_out1, timer0_out0} = tv[3:0];
   prc_pin_remap prc_pin_remap_i (.*);
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ==========================================
   // Helpers
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Request held until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
         @(posedge clk_sys);
      while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   task automatic wake_try(input logic sm, input logic [7:0] v, input logic x);
      sleep_mode <= sm;
      pv[7:0] <= 8'hFF;
      repeat (2) @(posedge clk_sys);
      pv[7:0] <= v;
      w = 1'b0;
      repeat (3)
      begin
         @(posedge clk_sys);
         #1;
         w = w | wake_req;
      end
      chk(w, x);
   endtask
   function automatic logic [5:0] exp_in(input logic [7:0] m, input logic [55:0] p);
      logic [3:0] i1;
      logic [3:0] i0;
      i1 = {p[39], p[33], p[21], p[4]};
      i0 = {p[38], p[32], p[20], p[3]};
      return {m[7] ? p[24] : p[18], m[6] ? p[27] : p[4], m[5] ? p[26] : p[2],
         m[4] ? p[34] : p[5], i1[m[3:2]], i0[m[1:0]]};
   endfunction
   task finish_test;
      if (n_fail == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (8000) @(posedge clk_sys);
      n_fail++;
      finish_test;
   end
   // ==========================================
   // Main sequence
   initial
   begin
      seed = $urandom(49945);
      {rst_n, psel, penable, pwrite, sleep_mode} = 5'b0_0000;
      {paddr, pwdata, timer_out_en, tv, pv} = '0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, `PRC_OFF_IN_REMAP, 0);
      chk(rd_v, 32'h0000_0000);
      for (k = 0; k < 7; k++)
      begin
         apb(1'b0, `PRC_OFF_DATA0 + 12'(4 * k), 0);
         chk(rd_v, 32'h0000_00FF);
         apb(1'b0, `PRC_OFF_DIR0 + 12'(4 * k), 0);
         chk(rd_v, 32'h0000_00FF);
      end
      // Outputs before any data write must drive high
      apb(1'b1, `PRC_OFF_DIR0 + 12'h004, 32'h0000_000F);
      chk({pb_oe, pb_out}, 16'hF0FF);
      r = $urandom;
      apb(1'b1, `PRC_OFF_DATA0 + 12'h004, r);
      chk({pb_oe, pb_out & 8'hF0}, {8'hF0, r[7:0] & 8'hF0});
      for (k = 0; k < 16; k++)
      begin
         r = ($urandom & 32'h0000_00F0) | k;
         pv <= {$urandom, $urandom};
         apb(1'b1, `PRC_OFF_IN_REMAP, r);
         apb(1'b0, `PRC_OFF_IN_REMAP, 0);
         chk(rd_v, r);
         chk({timer2_clock_in, timer1_clock_in, timer0_clock_in, ext_irq2_in, ext_irq1_in,
            ext_irq0_in}, exp_in(r[7:0], pv));
      end
      for (k = 0; k < 16; k++)
      begin
         b = k % 8;
         r = ($urandom & ~(32'h1 << b) & 32'h0000_00FF) | ((k / 8) << b);
         apb(1'b1, `PRC_OFF_OUT_REMAP, r);
         apb(1'b0, `PRC_OFF_OUT_REMAP, 0);
         chk(rd_v, r);
         tv <= $urandom;
         timer_out_en <= 8'h01 << b;
         @(posedge clk_sys);
         #1;
         chk({oe_v[PIN_T[2 * b + r[b]]], out_v[PIN_T[2 * b + r[b]]]}, {1'b1, tv[b]});
         chk(oe_v[PIN_T[2 * b + 1 - r[b]]], 1'b0);
      end
      timer_out_en <= 8'h00;
      // Bit operations on port C, lower half driven
      apb(1'b1, `PRC_OFF_DIR0 + 12'h008, 32'h0000_00F0);
      e = 32'h0000_00F0;
      for (k = 0; k < 8; k++)
      begin
         b = $urandom % 8;
         w = $urandom % 2;
         pv <= {$urandom, $urandom};
         apb(1'b1, `PRC_OFF_BIT_OP, {22'h0, w, k[0], 1'b0, 3'd2, 1'b0, b[2:0]});
         if (k[0])
         begin
            e[b] = w;
            apb(1'b0, `PRC_OFF_DIR0 + 12'h008, 0);
            chk(rd_v, e);
            chk(pc_oe, 8'(~e[7:0]));
         end
         else
         begin
            r = {24'h0, pc_in};
            r[b] = w;
            apb(1'b0, `PRC_OFF_DATA0 + 12'h008, 0);
            chk(rd_v, r);
         end
      end
      apb(1'b1, `PRC_OFF_BIT_OP, 32'h0000_0370);
      apb(1'b0, `PRC_OFF_DIR0 + 12'h008, 0);
      chk(rd_v, e);
      apb(1'b0, `PRC_OFF_PIN0 + 12'h008, 0);
      chk(rd_v, {24'h0, pc_in});
      apb(1'b0, `PRC_OFF_BIT_OP, 0);
      chk(rd_v, 32'h0000_0000);
      apb(1'b0, 12'hFFC, 0);
      chk(err_v, 1'b1);
      chk(rd_v, 32'h0000_0000);
      apb(1'b1, `PRC_OFF_WAKE_EN, 32'h0000_0010);
      wake_try(1'b1, 8'hEF, 1'b1);
      wake_try(1'b1, 8'hF7, 1'b0);
      wake_try(1'b0, 8'hEF, 1'b0);
      // Second reset in mid-run
      rst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, `PRC_OFF_DIR0 + 12'h008, 0);
      chk(rd_v, 32'h0000_00FF);
      chk(pc_oe, 8'h00);
      chk(oe_v[55:32], 24'h00_0000);
      chk(oe_v[31:0], 32'h0000_0000);
      chk(out_v[55:32], 24'hFF_FFFF);
      chk(out_v[31:0], 32'hFFFF_FFFF);
      finish_test;
   end
endmodule // prc_pin_remap_test
`default_nettype wire
